// ### design/boot_area_dma.sv
// Our own choices: the Avalon-MM interface to the registers and the address map.
module boot_area_dma (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic o_irq,
    output logic o_mem_valid,
    output logic [31:0] o_mem_addr,
    output logic [31:0] o_mem_data,
    input wire logic i_mem_ready,
    input wire logic i_mem_err,
    input wire logic i_fw_wr,
    input wire logic [6:0] i_fw_addr,
    input wire logic [31:0] i_fw_data,
    input wire logic i_fw_active_id,
    input wire logic [1:0] i_area_lock
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic bus_ack;
    logic wr_take;
    logic rd_take;
    logic [31:0] next_rdata;
    logic ctrl_en;
    logic [31:0] buf_base;
    logic [31:0] sel_reg;
    logic [1:0] status;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [1:0] irq_set;
    logic [1:0] irq_clr;
    boot_dma_pkg::copy_state_t state;
    logic [boot_dma_pkg::LEN_W-1:0] remaining;
    logic [boot_dma_pkg::MEM_ADDR_W-1:0] src_addr;
    logic [31:0] mem_rdata;
    logic sel_hit;
    logic start;
    logic [1:0] req_id;
    logic [boot_dma_pkg::LEN_W-1:0] req_size;
    logic [boot_dma_pkg::LEN_W-1:0] req_ofs;
    logic [boot_dma_pkg::LEN_W:0] req_end;
    logic req_bad;
    logic req_empty;
    logic beat_done;
    logic last_beat;
    logic fail_evt;
    logic done_evt;
    logic fw_wr_ok;

    // ------------------------------------------------------------
    // Bus slave handshake
    // ------------------------------------------------------------
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~bus_ack;
    assign wr_take = i_avs_write & bus_ack;
    assign rd_take = i_avs_read & bus_ack;

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            bus_ack <= 1'b0;
        end
        else
        begin
            bus_ack <= (i_avs_read | i_avs_write) & ~bus_ack;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        unique case (i_avs_address)
            boot_dma_pkg::OFS_CAP:
            begin
                next_rdata[boot_dma_pkg::CAP_SUPPORT_POS] = 1'b1;
            end
            boot_dma_pkg::OFS_CTRL:
            begin
                next_rdata[boot_dma_pkg::CTRL_EN_POS] = ctrl_en;
            end
            boot_dma_pkg::OFS_INFO:
            begin
                next_rdata[boot_dma_pkg::INFO_STATUS_LSB +: 2] = status;
                next_rdata[boot_dma_pkg::INFO_ACTIVE_POS] =
                    i_fw_active_id;
                next_rdata[boot_dma_pkg::INFO_SIZE_LSB +: 16] =
                    boot_dma_pkg::AREA_SIZE_FIELD;
            end
            boot_dma_pkg::OFS_BUF:
            begin
                next_rdata = buf_base;
            end
            boot_dma_pkg::OFS_SEL:
            begin
                next_rdata = sel_reg;
            end
            boot_dma_pkg::OFS_IRQ:
            begin
                next_rdata[1:0] = irq_stat;
            end
            boot_dma_pkg::OFS_MASK:
            begin
                next_rdata[1:0] = irq_mask;
            end
            default:
            begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            o_avs_readdata <= 32'h0000_0000;
        end
        else if (i_avs_read & ~bus_ack)
        begin
            o_avs_readdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            ctrl_en <= boot_dma_pkg::RST_CTRL_EN;
            buf_base <= boot_dma_pkg::RST_BUF;
            irq_mask <= boot_dma_pkg::RST_IRQ;
        end
        else if (wr_take)
        begin
            if (i_avs_address == boot_dma_pkg::OFS_CTRL)
            begin
                ctrl_en <= i_avs_writedata[boot_dma_pkg::CTRL_EN_POS];
            end
            if (i_avs_address == boot_dma_pkg::OFS_BUF)
            begin
                buf_base <= i_avs_writedata;
            end
            if (i_avs_address == boot_dma_pkg::OFS_MASK)
            begin
                irq_mask <= i_avs_writedata[1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    assign sel_hit = wr_take & (i_avs_address == boot_dma_pkg::OFS_SEL);
    assign start = sel_hit & (status != boot_dma_pkg::STAT_BUSY);
    assign req_id = i_avs_writedata[boot_dma_pkg::SEL_ID_LSB +: 2];
    assign req_size =
        i_avs_writedata[boot_dma_pkg::SEL_SIZE_LSB +: boot_dma_pkg::LEN_W];
    assign req_ofs =
        i_avs_writedata[boot_dma_pkg::SEL_OFS_LSB +: boot_dma_pkg::LEN_W];
    assign req_end = {1'b0, req_ofs} + {1'b0, req_size};
    assign req_bad = (req_id > 2'h1) |
        (req_end > boot_dma_pkg::AREA_WORDS);
    assign req_empty = (req_size == 12'h000);

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            sel_reg <= boot_dma_pkg::RST_SEL;
        end
        else if (start)
        begin
            sel_reg <= i_avs_writedata;
        end
    end

    // ------------------------------------------------------------
    // Copy engine
    // ------------------------------------------------------------
    assign o_mem_valid = (state == boot_dma_pkg::CP_SEND);
    assign beat_done = o_mem_valid & i_mem_ready;
    assign last_beat = (remaining == 12'h001);
    assign fail_evt = (start & req_bad) |
        (beat_done & i_mem_err);
    assign done_evt = (start & ~req_bad & req_empty) |
        (beat_done & ~i_mem_err & last_beat);

    // Runs regardless of ctrl_en
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            state <= boot_dma_pkg::CP_IDLE;
        end
        else
        begin
            unique case (state)
                boot_dma_pkg::CP_IDLE:
                begin
                    if (start & ~req_bad & ~req_empty)
                    begin
                        state <= boot_dma_pkg::CP_READ;
                    end
                end
                boot_dma_pkg::CP_READ:
                begin
                    state <= boot_dma_pkg::CP_LOAD;
                end
                boot_dma_pkg::CP_LOAD:
                begin
                    state <= boot_dma_pkg::CP_SEND;
                end
                boot_dma_pkg::CP_SEND:
                begin
                    if (beat_done)
                    begin
                        if (i_mem_err | last_beat)
                        begin
                            state <= boot_dma_pkg::CP_IDLE;
                        end
                        else
                        begin
                            state <= boot_dma_pkg::CP_READ;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            remaining <= 12'h000;
            src_addr <= 7'h00;
            o_mem_addr <= 32'h0000_0000;
        end
        else if (start & ~req_bad)
        begin
            remaining <= req_size;
            src_addr <= {req_id[0],
                req_ofs[boot_dma_pkg::AREA_ADDR_W-1:0]};
            o_mem_addr <= buf_base;
        end
        else if (beat_done)
        begin
            remaining <= remaining - 12'h001;
            src_addr <= src_addr + 7'h01;
            o_mem_addr <= o_mem_addr + boot_dma_pkg::WORD_BYTES;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            o_mem_data <= 32'h0000_0000;
        end
        else if (state == boot_dma_pkg::CP_LOAD)
        begin
            o_mem_data <= mem_rdata;
        end
    end

    // ------------------------------------------------------------
    // Status field
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            status <= boot_dma_pkg::STAT_IDLE;
        end
        else if (fail_evt)
        begin
            status <= boot_dma_pkg::STAT_ERR;
        end
        else if (done_evt)
        begin
            status <= boot_dma_pkg::STAT_DONE;
        end
        else if (start)
        begin
            status <= boot_dma_pkg::STAT_BUSY;
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    assign irq_set = {fail_evt, done_evt};
    assign irq_clr = (rd_take & (i_avs_address == boot_dma_pkg::OFS_IRQ))
        ? o_avs_readdata[1:0] : 2'h0;

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            irq_stat <= boot_dma_pkg::RST_IRQ;
        end
        else
        begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
        end
    end

    assign o_irq = |(irq_stat & irq_mask);

    // ------------------------------------------------------------
    // Boot area storage
    // ------------------------------------------------------------
    assign fw_wr_ok = i_fw_wr & ~i_area_lock[i_fw_addr[6]];

    boot_area_mem u_mem (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .i_wr(fw_wr_ok),
        .i_waddr(i_fw_addr),
        .i_wdata(i_fw_data),
        .i_rd(state == boot_dma_pkg::CP_READ),
        .i_raddr(src_addr),
        .o_rdata(mem_rdata)
    );

endmodule

// ### design/boot_dma_pkg.sv
package boot_dma_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CAP = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_INFO = 8'h08;
    localparam logic [7:0] OFS_BUF = 8'h0c;
    localparam logic [7:0] OFS_SEL = 8'h10;
    localparam logic [7:0] OFS_IRQ = 8'h14;
    localparam logic [7:0] OFS_MASK = 8'h18;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int LEN_W = 12;
    localparam int AREA_ADDR_W = 6;
    localparam int MEM_ADDR_W = 7;
    localparam int MEM_DEPTH = 128;
    localparam logic [LEN_W:0] AREA_WORDS = 13'h040;
    localparam logic [15:0] AREA_SIZE_FIELD = 16'h0040;
    localparam logic [31:0] WORD_BYTES = 32'h0000_0004;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CAP_SUPPORT_POS = 0;
    localparam int CTRL_EN_POS = 0;
    localparam int INFO_STATUS_LSB = 0;
    localparam int INFO_ACTIVE_POS = 4;
    localparam int INFO_SIZE_LSB = 16;
    localparam int SEL_OFS_LSB = 0;
    localparam int SEL_SIZE_LSB = 12;
    localparam int SEL_ID_LSB = 30;
    localparam int IRQ_DONE_POS = 0;
    localparam int IRQ_ERR_POS = 1;

    // ------------------------------------------------------------
    // Status codes and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] STAT_IDLE = 2'h0;
    localparam logic [1:0] STAT_BUSY = 2'h1;
    localparam logic [1:0] STAT_DONE = 2'h2;
    localparam logic [1:0] STAT_ERR = 2'h3;
    localparam logic [31:0] RST_BUF = 32'h0000_0000;
    localparam logic [31:0] RST_SEL = 32'h0000_0000;
    localparam logic [1:0] RST_IRQ = 2'h0;
    localparam logic RST_CTRL_EN = 1'b0;

    // ------------------------------------------------------------
    // Copy engine states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CP_IDLE,
        CP_READ,
        CP_LOAD,
        CP_SEND
    } copy_state_t;

endpackage

// ### design/boot_area_mem.sv
module boot_area_mem (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_wr,
    input wire logic [boot_dma_pkg::MEM_ADDR_W-1:0] i_waddr,
    input wire logic [boot_dma_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_rd,
    input wire logic [boot_dma_pkg::MEM_ADDR_W-1:0] i_raddr,
    output logic [boot_dma_pkg::DATA_W-1:0] o_rdata
);

    // ------------------------------------------------------------
    // Storage of both boot areas
    // ------------------------------------------------------------
    logic [boot_dma_pkg::DATA_W-1:0] mem [0:boot_dma_pkg::MEM_DEPTH-1];

    always_ff @(posedge i_mclk)
    begin
        if (i_wr)
        begin
            mem[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            o_rdata <= 32'h0000_0000;
        end
        else if (i_rd)
        begin
            o_rdata <= mem[i_raddr];
        end
    end

endmodule

// ### test/boot_area_dma_chk.sv
// ----------------------------------------
// Protocol checker for the boot area copier
// ----------------------------------------
module boot_area_dma_chk (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic o_avs_waitrequest,
    input wire logic o_irq,
    input wire logic o_mem_valid,
    input wire logic [31:0] o_mem_addr,
    input wire logic [31:0] o_mem_data,
    input wire logic i_mem_ready,
    input wire logic i_mem_err
);
    timeunit 1ns;
    timeprecision 1ns;
    logic in_run;
    logic [31:0] last_addr;
    logic sel_take;
    logic acc;
    assign sel_take = i_avs_write && !o_avs_waitrequest
        && i_avs_address == boot_dma_pkg::OFS_SEL;
    assign acc = o_mem_valid && i_mem_ready;
    always_ff @(posedge i_mclk)
    begin
        if (i_srst || sel_take)
        begin
            in_run <= 1'b0;
        end
        else if (acc)
        begin
            in_run <= !i_mem_err;
        end
    end
    always_ff @(posedge i_mclk)
    begin
        if (acc)
        begin
            last_addr <= o_mem_addr;
        end
    end
    default clocking @(posedge i_mclk);
    endclocking
    default disable iff (i_srst);
    AST_WAIT_ONE: assert property (
        (i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest) else $error("wait not one cycle");
    AST_NO_IDLE_WAIT: assert property (
        !(i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
        else $error("wait without request");
    AST_TAKE_AFTER_WAIT: assert property (
        i_avs_read && !o_avs_waitrequest
        |-> $past(o_avs_waitrequest) && $past(i_avs_read))
        else $error("read taken without wait");
    AST_BEAT_HOLD: assert property (
        o_mem_valid && !i_mem_ready |=> o_mem_valid
        && $stable(o_mem_addr) && $stable(o_mem_data))
        else $error("beat changed while stalled");
    AST_BEAT_GAP: assert property (
        acc |=> !o_mem_valid [*2]) else $error("beats too close");
    AST_ERR_STOP: assert property (
        acc && i_mem_err |=> !o_mem_valid [*4])
        else $error("copy went on after error");
    AST_ADDR_STEP: assert property (
        $rose(o_mem_valid) && in_run |-> o_mem_addr == last_addr + 32'h4)
        else $error("beat address not ascending");
    AST_RESET_QUIET: assert property (
        disable iff (1'b0) i_srst |=> !o_mem_valid && !o_irq)
        else $error("outputs active after reset");
endmodule

bind boot_area_dma boot_area_dma_chk boot_area_dma_chk_inst (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write),
    .o_avs_waitrequest(o_avs_waitrequest),
    .o_irq(o_irq),
    .o_mem_valid(o_mem_valid),
    .o_mem_addr(o_mem_addr),
    .o_mem_data(o_mem_data),
    .i_mem_ready(i_mem_ready),
    .i_mem_err(i_mem_err)
);

// ### test/host_mem_model.sv
// ----------------------------------------
// Host memory taking copy beats
// ----------------------------------------
module host_mem_model (
    input wire logic i_mclk,
    input wire logic i_valid,
    input wire logic [31:0] i_addr,
    input wire logic [31:0] i_data,
    input wire logic i_slow,
    input wire logic i_fail,
    output logic o_ready,
    output logic o_err
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] mem [logic [31:0]];
    initial
    begin
        o_ready = 1'b0;
        o_err = 1'b0;
    end
    always @(posedge i_mclk)
    begin
        if (i_valid && o_ready && !o_err)
        begin
            mem[i_addr] = i_data;
        end
        o_ready <= i_slow ? 1'($urandom_range(1, 0)) : 1'b1;
        o_err <= i_fail;
    end
endmodule

// ### test/boot_area_dma_tb.sv
`define CHK(a, b) \
    begin \
        checked++; \
        if ((a) !== (b)) \
        begin \
            n_mismatch++; \
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); \
        end \
    end

// ----------------------------------------
// Bench for the boot area copier
// ----------------------------------------
module boot_area_dma_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] avs_addr = 8'h00;
    logic avs_rd = 1'b0;
    logic avs_wr = 1'b0;
    logic [31:0] avs_wdata = 32'h0;
    logic [31:0] avs_rdata;
    logic avs_wait;
    logic irq;
    logic m_valid;
    logic [31:0] m_addr;
    logic [31:0] m_data;
    logic m_ready;
    logic m_err;
    logic fw_wr = 1'b0;
    logic [6:0] fw_addr = 7'h00;
    logic [31:0] fw_data = 32'h0;
    logic act_id = 1'b0;
    logic [1:0] lock = 2'h0;
    logic slow = 1'b0;
    logic fail = 1'b0;
    logic [31:0] area [128];
    logic [31:0] base;
    int n_mismatch = 0;
    int checked = 0;

    always #5 mclk = ~mclk;

    boot_area_dma boot_area_dma_inst (
        .i_mclk(mclk),
        .i_srst(srst),
        .i_avs_address(avs_addr),
        .i_avs_read(avs_rd),
        .i_avs_write(avs_wr),
        .i_avs_writedata(avs_wdata),
        .o_avs_readdata(avs_rdata),
        .o_avs_waitrequest(avs_wait),
        .o_irq(irq),
        .o_mem_valid(m_valid),
        .o_mem_addr(m_addr),
        .o_mem_data(m_data),
        .i_mem_ready(m_ready),
        .i_mem_err(m_err),
        .i_fw_wr(fw_wr),
        .i_fw_addr(fw_addr),
        .i_fw_data(fw_data),
        .i_fw_active_id(act_id),
        .i_area_lock(lock)
    );

    host_mem_model host_mem_model_inst (
        .i_mclk(mclk),
        .i_valid(m_valid),
        .i_addr(m_addr),
        .i_data(m_data),
        .i_slow(slow),
        .i_fail(fail),
        .o_ready(m_ready),
        .o_err(m_err)
    );

    task automatic close_out;
        $display("checks=%0d mismatches=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        avs_addr <= a;
        avs_wdata <= d;
        avs_wr <= w;
        avs_rd <= !w;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (avs_wait !== 1'b0);
        q = avs_rdata;
        avs_rd <= 1'b0;
        avs_wr <= 1'b0;
        @(posedge mclk);
        `CHK(n < 50, 1'b1);
    endtask

    task automatic fw_load(input logic [1:0] lk);
        logic [31:0] d;
        lock <= lk;
        for (int i = 0; i < 128; i++)
        begin
            d = $urandom;
            fw_wr <= 1'b1;
            fw_addr <= 7'(i);
            fw_data <= d;
            if (!lk[i / 64]) area[i] = d;
            @(posedge mclk);
        end
        fw_wr <= 1'b0;
    endtask

    task automatic run(input int id, input int off, input int sz,
        input logic sl, input logic fl);
        logic [31:0] q;
        logic [31:0] sel;
        logic [31:0] got;
        logic [1:0] ebit;
        logic [1:0] msk;
        int est;
        int n;
        host_mem_model_inst.mem.delete();
        slow <= sl;
        fail <= fl;
        msk = 2'($urandom_range(3, 0));
        bus(1'b1, boot_dma_pkg::OFS_MASK, {30'h0, msk}, q);
        base = $urandom & 32'hffff_fffc;
        bus(1'b1, boot_dma_pkg::OFS_BUF, base, q);
        bus(1'b0, boot_dma_pkg::OFS_BUF, 32'h0, q);
        `CHK(q, base);
        est = (id > 1 || off + sz > 64 || (fl && sz > 0)) ? 3 : 2;
        sel = (32'(id) << 30) | (32'(sz) << 12) | 32'(off);
        bus(1'b1, boot_dma_pkg::OFS_SEL, sel, q);
        if (id < 2 && off + sz <= 64 && sz > 0)
        begin
            bus(1'b0, boot_dma_pkg::OFS_INFO, 32'h0, q);
            `CHK(q[1:0], boot_dma_pkg::STAT_BUSY);
        end
        if (sl && sz > 8 && est == 2)
        begin
            bus(1'b1, boot_dma_pkg::OFS_SEL, 32'h0000_1000, q);
            bus(1'b0, boot_dma_pkg::OFS_SEL, 32'h0, q);
            `CHK(q, sel);
        end
        n = 0;
        do
        begin
            bus(1'b0, boot_dma_pkg::OFS_INFO, 32'h0, q);
            n++;
        end
        while (q[1:0] === boot_dma_pkg::STAT_BUSY && n < 400);
        `CHK(q[1:0], 2'(est));
        `CHK(q[4], act_id);
        if (est == 2)
        begin
            for (int k = 0; k < sz; k++)
            begin
                got = host_mem_model_inst.mem[base + 32'(4 * k)];
                `CHK(got, area[id * 64 + off + k]);
            end
        end
        else
        begin
            `CHK(host_mem_model_inst.mem.num(), 0);
        end
        ebit = (est == 2) ? 2'h1 : 2'h2;
        `CHK(irq, |(msk & ebit));
        bus(1'b0, boot_dma_pkg::OFS_IRQ, 32'h0, q);
        `CHK(q, {30'h0, ebit});
        `CHK(irq, 1'b0);
        $display("test end area=%0d ofs=%0d size=%0d", id, off, sz);
    endtask

    initial
    begin
        logic [31:0] q;
        int o;
        void'($urandom(32342));
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        `CHK(irq, 1'b0);
        bus(1'b0, boot_dma_pkg::OFS_CAP, 32'h0, q);
        `CHK(q[0], 1'b1);
        bus(1'b0, boot_dma_pkg::OFS_INFO, 32'h0, q);
        `CHK(q, {boot_dma_pkg::AREA_SIZE_FIELD, 11'h0, act_id, 4'h0});
        bus(1'b0, 8'h1c, 32'h0, q);
        `CHK(q, 32'h0);
        fw_load(2'b00);
        for (int i = 0; i < 12; i++)
        begin
            act_id <= i[0];
            bus(1'b1, boot_dma_pkg::OFS_CTRL, 32'(i[2]), q);
            bus(1'b0, boot_dma_pkg::OFS_CTRL, 32'h0, q);
            `CHK(q[0], i[2]);
            o = $urandom_range(63, 0);
            run(i % 2, o, $urandom_range(64 - o, 1), i[1], 1'b0);
        end
        run(0, 0, 64, 1'b0, 1'b0);
        run(1, 60, 4, 1'b1, 1'b0);
        run(0, 60, 5, 1'b0, 1'b0);
        run(2, 0, 1, 1'b0, 1'b0);
        run(1, 0, 0, 1'b0, 1'b0);
        run(0, 8, 16, 1'b1, 1'b1);
        run(0, 8, 16, 1'b1, 1'b0);
        fw_load(2'b10);
        run(1, 0, 64, 1'b0, 1'b0);
        run(0, 0, 64, 1'b1, 1'b0);
        act_id <= 1'b0;
        bus(1'b0, boot_dma_pkg::OFS_INFO, 32'h0, q);
        `CHK(q[4], 1'b0);
        close_out;
    end

    initial
    begin
        #500000;
        n_mismatch++;
        close_out;
    end
endmodule
